// ### design/sse_core.sv
// Stack and single-bit shift execution unit with an AXI4-Lite register slave
`timescale 1ns/1ps

module sse_core
	import sse_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire sse_pkg::sse_axi_req_t axi_req,
	output      sse_pkg::sse_axi_rsp_t axi_rsp
);
	import sse_pkg::*;

	typedef enum logic [1:0] {SSE_IDLE, SSE_EXEC, SSE_RETI2} sse_phase_t;

	typedef struct packed {
		sse_phase_t          phase;
		sse_op_t             op;
		logic                byte_op;
		logic                to_reg;
		logic [15:0]         stack_ptr;
		logic [15:0]         program_counter;
		logic [15:0]         status_word;
		logic [15:0]         opnd;
		logic [15:0][15:0]   mem;
		logic                viol;
		logic                aw_held;
		logic [7:0]          awaddr;
		logic                w_held;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		sse_axi_rsp_t        rsp;
	} sse_state_t;

	sse_state_t state;
	sse_state_t next_state;

	assign axi_rsp = state.rsp;

	// Byte-lane merge; only the two low lanes hold bits
	function automatic logic [15:0] sse_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] m;
		m = old;
		if (s[0]) begin
			m[7:0] = d[7:0];
		end
		if (s[1]) begin
			m[15:8] = d[15:8];
		end
		return m;
	endfunction

	// ****************************************
	// Shift and stack-address datapath
	// ****************************************
	logic        cin;
	logic        msb;
	logic [7:0]  hi_keep;
	logic [15:0] sh_res;
	logic        sh_c;
	logic        sh_v;
	logic        sh_n;
	logic        sh_z;
	logic [3:0]  sp_idx;
	logic [3:0]  push_idx;
	logic [15:0] sp_dec;
	logic [15:0] sp_inc;
	logic [15:0] stack_top;

	always_comb begin
		cin     = state.status_word[SSE_SW_C];
		msb     = state.byte_op ? state.opnd[7] : state.opnd[15];
		hi_keep = state.to_reg ? 8'h00 : state.opnd[15:8];
		sh_res  = state.opnd;
		sh_c    = 1'b0;
		sh_v    = 1'b0;
		unique case (state.op)
			SSE_OP_RLA, SSE_OP_RLC: begin
				sh_res = {state.opnd[14:0], (state.op == SSE_OP_RLC) ? cin : 1'b0};
				sh_c   = msb;
				if (state.byte_op) begin
					sh_res[15:8] = hi_keep;
					sh_v = (state.opnd[7:0] >= SSE_B_OV_LO) && (state.opnd[7:0] < SSE_B_OV_HI);
				end else begin
					sh_v = (state.opnd >= SSE_W_OV_LO) && (state.opnd < SSE_W_OV_HI);
				end
			end
			SSE_OP_RRA, SSE_OP_RRC: begin
				sh_c = state.opnd[0];
				if (state.byte_op) begin
					sh_res = {hi_keep, (state.op == SSE_OP_RRC) ? cin : state.opnd[7], state.opnd[7:1]};
				end else begin
					sh_res = {(state.op == SSE_OP_RRC) ? cin : state.opnd[15], state.opnd[15:1]};
				end
			end
			default: begin
				sh_res = state.opnd;
			end
		endcase
		sh_n = state.byte_op ? sh_res[7] : sh_res[15];
		sh_z = state.byte_op ? (sh_res[7:0] == 8'h00) : (sh_res == 16'h0000);
	end

	assign sp_dec   = state.stack_ptr - SSE_SP_STEP;
	assign sp_inc   = state.stack_ptr + SSE_SP_STEP;
	assign sp_idx   = state.stack_ptr[4:1];
	assign push_idx = sp_dec[4:1];
	assign stack_top      = state.mem[sp_idx];

	// ****************************************
	// Next state
	// ****************************************
	logic        wr_fire;
	logic        rd_fire;
	logic [7:0]  wa;
	logic [31:0] rd;
	logic        viol_set;
	logic        viol_clr;

	always_comb begin
		next_state = state;
		viol_set   = 1'b0;
		viol_clr   = 1'b0;
		rd         = 32'h0000_0000;

		// Execution
		unique case (state.phase)
			SSE_IDLE: begin
			end
			SSE_EXEC: begin
				next_state.phase = SSE_IDLE;
				unique case (state.op)
					SSE_OP_POP: begin
						next_state.stack_ptr = sp_inc;
						if (state.byte_op) begin
							next_state.opnd = {hi_keep, stack_top[7:0]};
						end else begin
							next_state.opnd = stack_top;
						end
					end
					SSE_OP_PUSH: begin
						next_state.stack_ptr     = sp_dec;
						next_state.mem[push_idx] = state.opnd;
						if (sp_dec == SSE_WDOG_ADDR && state.opnd[15:8] != SSE_WDOG_KEY) begin
							viol_set = 1'b1;
						end
					end
					SSE_OP_RET: begin
						next_state.program_counter = stack_top;
						next_state.stack_ptr       = sp_inc;
					end
					SSE_OP_INTERRUPT_EXIT: begin
						next_state.status_word = stack_top;
						next_state.stack_ptr   = sp_inc;
						next_state.phase       = SSE_RETI2;
					end
					default: begin
						next_state.opnd                     = sh_res;
						next_state.status_word[SSE_SW_N]    = sh_n;
						next_state.status_word[SSE_SW_Z]    = sh_z;
						next_state.status_word[SSE_SW_C]    = sh_c;
						next_state.status_word[SSE_SW_V]    = sh_v;
					end
				endcase
			end
			SSE_RETI2: begin
				next_state.program_counter = stack_top;
				next_state.stack_ptr       = sp_inc;
				next_state.phase           = SSE_IDLE;
			end
		endcase

		// Write channel: address and data taken in either order
		if (axi_req.awvalid && state.rsp.awready) begin
			next_state.aw_held     = 1'b1;
			next_state.awaddr      = axi_req.awaddr;
			next_state.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && state.rsp.wready) begin
			next_state.w_held     = 1'b1;
			next_state.wdata      = axi_req.wdata;
			next_state.wstrb      = axi_req.wstrb;
			next_state.rsp.wready = 1'b0;
		end
		wr_fire = state.aw_held && state.w_held && !state.rsp.bvalid;
		wa      = state.awaddr;
		if (wr_fire) begin
			next_state.aw_held    = 1'b0;
			next_state.w_held     = 1'b0;
			next_state.rsp.bvalid = 1'b1;
			next_state.rsp.bresp  = SSE_OKAY;
			// Register writes during an operation, other than the status clear, are dropped to keep the sequence atomic
			if (wa >= SSE_MEM_OFS && wa < SSE_MEM_OFS + 8'(4 * SSE_MEM_WORDS) && wa[1:0] == 2'b00) begin
				if (state.phase == SSE_IDLE) begin
					next_state.mem[wa[5:2]] = sse_merge(state.mem[wa[5:2]], state.wdata, state.wstrb);
				end
			end else begin
				unique case (wa)
					SSE_CTRL_OFS: begin
						if (state.phase == SSE_IDLE && state.wstrb[0]) begin
							next_state.op      = sse_op_t'(state.wdata[3:0]);
							next_state.byte_op = state.wdata[SSE_CTRL_BYTE_BIT];
							next_state.to_reg  = state.wdata[SSE_CTRL_REG_BIT];
							next_state.phase   = SSE_EXEC;
						end
					end
					SSE_STAT_OFS: begin
						viol_clr = state.wstrb[0] && state.wdata[SSE_STAT_VIOL_BIT];
					end
					SSE_SP_OFS: begin
						if (state.phase == SSE_IDLE) begin
							next_state.stack_ptr = sse_merge(state.stack_ptr, state.wdata, state.wstrb);
						end
					end
					SSE_PC_OFS: begin
						if (state.phase == SSE_IDLE) begin
							next_state.program_counter = sse_merge(state.program_counter, state.wdata, state.wstrb);
						end
					end
					SSE_SW_OFS: begin
						if (state.phase == SSE_IDLE) begin
							next_state.status_word = sse_merge(state.status_word, state.wdata, state.wstrb);
						end
					end
					SSE_OPND_OFS: begin
						if (state.phase == SSE_IDLE) begin
							next_state.opnd = sse_merge(state.opnd, state.wdata, state.wstrb);
						end
					end
					default: begin
						next_state.rsp.bresp = SSE_SLVERR;
					end
				endcase
			end
		end
		if (state.rsp.bvalid && axi_req.bready) begin
			next_state.rsp.bvalid  = 1'b0;
			next_state.rsp.awready = 1'b1;
			next_state.rsp.wready  = 1'b1;
		end

		// Set wins over clear so a violation is never lost
		if (viol_set) begin
			next_state.viol = 1'b1;
		end else if (viol_clr) begin
			next_state.viol = 1'b0;
		end

		// Read channel
		rd_fire = axi_req.arvalid && state.rsp.arready;
		if (rd_fire) begin
			next_state.rsp.arready = 1'b0;
			next_state.rsp.rvalid  = 1'b1;
			next_state.rsp.rresp   = SSE_OKAY;
			if (axi_req.araddr >= SSE_MEM_OFS && axi_req.araddr < SSE_MEM_OFS + 8'(4 * SSE_MEM_WORDS)
				&& axi_req.araddr[1:0] == 2'b00) begin
				rd = {16'h0000, state.mem[axi_req.araddr[5:2]]};
			end else begin
				unique case (axi_req.araddr)
					SSE_CTRL_OFS: rd = {26'h0, state.to_reg, state.byte_op, state.op};
					SSE_STAT_OFS: rd = {30'h0, state.viol, state.phase != SSE_IDLE};
					SSE_SP_OFS:   rd = {16'h0000, state.stack_ptr};
					SSE_PC_OFS:   rd = {16'h0000, state.program_counter};
					SSE_SW_OFS:   rd = {16'h0000, state.status_word};
					SSE_OPND_OFS: rd = {16'h0000, state.opnd};
					default: begin
						next_state.rsp.rresp = SSE_SLVERR;
					end
				endcase
			end
			next_state.rsp.rdata = rd;
		end
		if (state.rsp.rvalid && axi_req.rready) begin
			next_state.rsp.rvalid  = 1'b0;
			next_state.rsp.arready = 1'b1;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state             <= '0;
			state.phase       <= SSE_IDLE;
			state.op          <= SSE_OP_POP;
			state.stack_ptr   <= SSE_RST_WORD;
			state.rsp.awready <= 1'b1;
			state.rsp.wready  <= 1'b1;
			state.rsp.arready <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking sse_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic was_exec;
	assign was_exec = state.phase == SSE_EXEC;

	pop_step_a: assert property (was_exec && state.op == SSE_OP_POP |=>
		state.stack_ptr == $past(state.stack_ptr) + SSE_SP_STEP
		&& state.opnd[7:0] == $past(stack_top[7:0]))
		else $error("pop did not step or load");
	pop_byte_a: assert property (was_exec && state.op == SSE_OP_POP && state.byte_op && state.to_reg |=>
		state.opnd[15:8] == 8'h00)
		else $error("byte pop left upper byte");
	push_store_a: assert property (was_exec && state.op == SSE_OP_PUSH |=>
		state.stack_ptr == $past(state.stack_ptr) - SSE_SP_STEP
		&& state.mem[state.stack_ptr[4:1]] == $past(state.opnd))
		else $error("push wrong address or data");
	stack_flags_a: assert property (was_exec && state.op inside {SSE_OP_POP, SSE_OP_PUSH, SSE_OP_RET} |=>
		state.status_word == $past(state.status_word))
		else $error("stack op changed status word");
	ret_load_a: assert property (was_exec && state.op == SSE_OP_RET |=>
		state.program_counter == $past(stack_top) && state.stack_ptr == $past(state.stack_ptr) + SSE_SP_STEP)
		else $error("subroutine exit wrong");
	interrupt_exit_seq_a: assert property (was_exec && state.op == SSE_OP_INTERRUPT_EXIT |=>
		state.status_word == $past(stack_top) ##1
		state.stack_ptr == $past(state.stack_ptr, 2) + 16'h0004 && state.phase == SSE_IDLE)
		else $error("interrupt exit sequence wrong");
	shl_carry_a: assert property (was_exec && state.op == SSE_OP_RLA && !state.byte_op |=>
		state.status_word[SSE_SW_C] == $past(state.opnd[15]) && state.opnd[0] == 1'b0)
		else $error("shift left carry or fill wrong");
	word_ovf_a: assert property (was_exec && state.op inside {SSE_OP_RLA, SSE_OP_RLC} && !state.byte_op |=>
		state.status_word[SSE_SW_V] == ($past(state.opnd[15]) != $past(state.opnd[14])))
		else $error("word overflow wrong");
	byte_ovf_a: assert property (was_exec && state.op inside {SSE_OP_RLA, SSE_OP_RLC} && state.byte_op |=>
		state.status_word[SSE_SW_V] == ($past(state.opnd[7]) != $past(state.opnd[6])))
		else $error("byte overflow wrong");
	shr_flags_a: assert property (was_exec && state.op == SSE_OP_RRA |=>
		state.status_word[SSE_SW_V] == 1'b0 && state.status_word[SSE_SW_C] == $past(state.opnd[0]))
		else $error("shift right flags wrong");
	rrc_msb_a: assert property (was_exec && state.op == SSE_OP_RRC && !state.byte_op |=>
		state.opnd[15] == $past(state.status_word[SSE_SW_C]))
		else $error("rotate right msb wrong");
	mode_keep_a: assert property (was_exec
		&& state.op inside {SSE_OP_PUSH, SSE_OP_RLA, SSE_OP_RLC, SSE_OP_RRA, SSE_OP_RRC} |=>
		$stable(state.status_word[SSE_SW_OSC:SSE_SW_GIE]))
		else $error("mode bits changed");
	wdog_viol_a: assert property (was_exec && state.op == SSE_OP_PUSH && sp_dec == SSE_WDOG_ADDR
		&& state.opnd[15:8] != SSE_WDOG_KEY |=> state.viol)
		else $error("watchdog violation missed");

	interrupt_exit_cov: cover property (was_exec && state.op == SSE_OP_INTERRUPT_EXIT ##2 state.phase == SSE_IDLE);
	push_pop_cov: cover property (was_exec && state.op == SSE_OP_PUSH ##[1:20] was_exec && state.op == SSE_OP_POP);
	ovf_cov: cover property (was_exec && state.op == SSE_OP_RLA ##1 state.status_word[SSE_SW_V]);
	viol_cov: cover property ($rose(state.viol));

endmodule

// ### design/sse_pkg.sv
// Package: register map, field layout, operations and bus carriers of the stack and shift unit
package sse_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] SSE_CTRL_OFS     = 8'h00;
	localparam logic [7:0] SSE_STAT_OFS     = 8'h04;
	localparam logic [7:0] SSE_SP_OFS       = 8'h08;
	localparam logic [7:0] SSE_PC_OFS       = 8'h0C;
	localparam logic [7:0] SSE_SW_OFS       = 8'h10;
	localparam logic [7:0] SSE_OPND_OFS     = 8'h14;
	localparam logic [7:0] SSE_MEM_OFS      = 8'h40;
	localparam int         SSE_MEM_WORDS    = 16;

	// ****************************************
	// Fields
	// ****************************************
	localparam int SSE_CTRL_BYTE_BIT = 4;
	localparam int SSE_CTRL_REG_BIT  = 5;
	localparam int SSE_STAT_BUSY_BIT = 0;
	localparam int SSE_STAT_VIOL_BIT = 1;
	localparam int SSE_SW_C   = 0;
	localparam int SSE_SW_Z   = 1;
	localparam int SSE_SW_N   = 2;
	localparam int SSE_SW_GIE = 3;
	localparam int SSE_SW_CPU = 4;
	localparam int SSE_SW_OSC = 5;
	localparam int SSE_SW_V   = 8;

	// ****************************************
	// Constants
	// ****************************************
	localparam logic [15:0] SSE_SP_STEP   = 16'h0002;
	localparam logic [15:0] SSE_W_OV_LO   = 16'h4000;
	localparam logic [15:0] SSE_W_OV_HI   = 16'hC000;
	localparam logic [7:0]  SSE_B_OV_LO   = 8'h40;
	localparam logic [7:0]  SSE_B_OV_HI   = 8'hC0;
	localparam logic [15:0] SSE_WDOG_ADDR = 16'h0120;
	localparam logic [7:0]  SSE_WDOG_KEY  = 8'hA5;
	localparam logic [15:0] SSE_RST_WORD  = 16'h0000;
	localparam logic [1:0]  SSE_OKAY      = 2'h0;
	localparam logic [1:0]  SSE_SLVERR    = 2'h2;

	typedef enum logic [3:0] {
		SSE_OP_POP, SSE_OP_PUSH, SSE_OP_RET, SSE_OP_INTERRUPT_EXIT,
		SSE_OP_RLA, SSE_OP_RLC, SSE_OP_RRA, SSE_OP_RRC
	} sse_op_t;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} sse_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} sse_axi_rsp_t;

endpackage

// ### verif/sse_core_tb.sv
// Self-checking bench for the stack and shift unit
`timescale 1ns/1ps

module sse_core_tb;
	import sse_pkg::*;

	logic         aclk;
	logic         aresetn;
	sse_axi_req_t axi_req;
	sse_axi_rsp_t axi_rsp;
	int           errors;
	int           comparisons;

	sse_core dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp));
	sse_host host_u (.aclk(aclk), .axi_rsp(axi_rsp), .axi_req(axi_req));

	initial aclk = 1'b0;
	always #20 aclk = ~aclk;

	// ****************************************
	// Helpers
	// ****************************************
	task automatic wrap_up;
		errors += host_u.hang;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		host_u.wr(a, {16'h0000, d}, r);
		if (host_u.hang != 0) wrap_up();
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		host_u.rd(a, d, r);
		if (host_u.hang != 0) wrap_up();
		chk(what, d, {16'h0000, exp});
	endtask

	// Polling busy keeps the bench free of any assumed execution latency
	task automatic run(input sse_op_t op, input logic b, input logic r);
		logic [31:0] d;
		logic [1:0]  rs;
		int          n;
		wreg(SSE_CTRL_OFS, {10'h000, r, b, op});
		for (n = 0; n < 20; n++) begin
			host_u.rd(SSE_STAT_OFS, d, rs);
			if (d[SSE_STAT_BUSY_BIT] === 1'b0) break;
		end
		if (n == 20) begin
			errors++;
			wrap_up();
		end
	endtask

	function automatic logic [7:0] maddr(input logic [15:0] sa);
		return SSE_MEM_OFS + {2'h0, sa[4:1], 2'h0};
	endfunction

	// Byte results go to a register, so their upper byte is always cleared
	function automatic logic [31:0] model(input sse_op_t op, input logic b, input logic [15:0] x,
		input logic [15:0] sw);
		logic [15:0] xs;
		logic [15:0] y;
		logic [15:0] s;
		int          m;
		m = b ? 7 : 15;
		xs = b ? {8'h00, x[7:0]} : x;
		s = sw;
		y = xs >> 1;
		s[SSE_SW_V] = 1'b0;
		case (op)
			SSE_OP_RLA, SSE_OP_RLC: begin
				y = {xs[14:0], (op == SSE_OP_RLC) & sw[SSE_SW_C]};
				s[SSE_SW_V] = b ? (x[7:0] >= SSE_B_OV_LO && x[7:0] < SSE_B_OV_HI)
					: (x >= SSE_W_OV_LO && x < SSE_W_OV_HI);
			end
			SSE_OP_RRA: y[m] = xs[m];
			default: y[m] = sw[SSE_SW_C];
		endcase
		s[SSE_SW_C] = (op == SSE_OP_RLA || op == SSE_OP_RLC) ? xs[m] : xs[0];
		if (b) y[15:8] = 8'h00;
		s[SSE_SW_N] = y[m];
		s[SSE_SW_Z] = (y == 16'h0000);
		return {s, y};
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_bus;
		logic [31:0] d;
		logic [1:0]  r;
		rchk("reset stack_ptr", SSE_SP_OFS, 16'h0000);
		host_u.rd(8'h3C, d, r);
		chk("unmapped read resp", {30'h0, r}, {30'h0, SSE_SLVERR});
		chk("unmapped read data", d, 32'h0000_0000);
		host_u.wr(8'h30, 32'h0000_FFFF, r);
		chk("unmapped write resp", {30'h0, r}, {30'h0, SSE_SLVERR});
	endtask

	task automatic t_stack;
		wreg(SSE_SW_OFS, 16'h013F);
		wreg(maddr(16'h0010), 16'hBEEF);
		wreg(SSE_SP_OFS, 16'h0010);
		wreg(SSE_OPND_OFS, 16'h1234);
		run(SSE_OP_PUSH, 1'b0, 1'b1);
		rchk("sp after push", SSE_SP_OFS, 16'h000E);
		rchk("pushed word", maddr(16'h000E), 16'h1234);
		wreg(SSE_OPND_OFS, 16'hFFFF);
		run(SSE_OP_POP, 1'b1, 1'b1);
		rchk("byte pop", SSE_OPND_OFS, 16'h0034);
		rchk("sp after byte pop", SSE_SP_OFS, 16'h0010);
		run(SSE_OP_POP, 1'b0, 1'b1);
		rchk("word pop", SSE_OPND_OFS, 16'hBEEF);
		rchk("sp after pop", SSE_SP_OFS, 16'h0012);
		run(SSE_OP_PUSH, 1'b1, 1'b1);
		rchk("sp after byte push", SSE_SP_OFS, 16'h0010);
		wreg(SSE_OPND_OFS, 16'h5500);
		run(SSE_OP_POP, 1'b1, 1'b0);
		rchk("byte pop to memory", SSE_OPND_OFS, 16'h55EF);
		rchk("sp after memory pop", SSE_SP_OFS, 16'h0012);
		rchk("flags kept", SSE_SW_OFS, 16'h013F);
	endtask

	task automatic t_exit;
		wreg(SSE_SP_OFS, 16'h0004);
		wreg(maddr(16'h0004), 16'h3456);
		wreg(maddr(16'h0006), 16'h0129);
		wreg(maddr(16'h0008), 16'h4442);
		run(SSE_OP_RET, 1'b0, 1'b0);
		rchk("return address", SSE_PC_OFS, 16'h3456);
		rchk("sp after return", SSE_SP_OFS, 16'h0006);
		rchk("flags after return", SSE_SW_OFS, 16'h013F);
		run(SSE_OP_INTERRUPT_EXIT, 1'b0, 1'b0);
		rchk("restored status", SSE_SW_OFS, 16'h0129);
		rchk("restored counter", SSE_PC_OFS, 16'h4442);
		rchk("sp after irq exit", SSE_SP_OFS, 16'h000A);
	endtask

	// Incoming status has V, N, Z and all mode bits set so each must be recomputed or kept
	task automatic sh(input sse_op_t op, input logic b, input logic [15:0] x, input logic c);
		logic [15:0] sw;
		logic [31:0] e;
		sw = 16'h013E | {15'h0000, c};
		e = model(op, b, x, sw);
		wreg(SSE_SW_OFS, sw);
		wreg(SSE_OPND_OFS, x);
		run(op, b, 1'b1);
		rchk("shift result", SSE_OPND_OFS, e[15:0]);
		rchk("shift flags", SSE_SW_OFS, e[31:16]);
	endtask

	task automatic t_shift;
		sh(SSE_OP_RLA, 1'b0, 16'h4000, 1'b0);
		sh(SSE_OP_RLA, 1'b0, 16'hBFFF, 1'b1);
		sh(SSE_OP_RLA, 1'b0, 16'hC000, 1'b0);
		sh(SSE_OP_RLA, 1'b0, 16'h3FFF, 1'b0);
		sh(SSE_OP_RLA, 1'b0, 16'h8000, 1'b0);
		sh(SSE_OP_RLA, 1'b1, 16'hAB40, 1'b0);
		sh(SSE_OP_RLA, 1'b1, 16'h12C0, 1'b0);
		sh(SSE_OP_RLC, 1'b0, 16'h8000, 1'b1);
		sh(SSE_OP_RLC, 1'b1, 16'h55BF, 1'b1);
		sh(SSE_OP_RLC, 1'b0, 16'h0000, 1'b0);
		sh(SSE_OP_RRA, 1'b0, 16'h8001, 1'b0);
		sh(SSE_OP_RRA, 1'b1, 16'h12F1, 1'b0);
		sh(SSE_OP_RRA, 1'b0, 16'h0001, 1'b0);
		sh(SSE_OP_RRC, 1'b0, 16'h0001, 1'b1);
		sh(SSE_OP_RRC, 1'b1, 16'h34F2, 1'b1);
		sh(SSE_OP_RRC, 1'b0, 16'h0001, 1'b0);
	endtask

	task automatic t_wdog;
		wreg(SSE_SP_OFS, 16'h0122);
		wreg(SSE_OPND_OFS, 16'h1200);
		run(SSE_OP_PUSH, 1'b0, 1'b1);
		rchk("keyless write", SSE_STAT_OFS, 16'h0002);
		wreg(SSE_STAT_OFS, 16'h0002);
		rchk("violation cleared", SSE_STAT_OFS, 16'h0000);
		wreg(SSE_SP_OFS, 16'h0122);
		wreg(SSE_OPND_OFS, {SSE_WDOG_KEY, 8'h12});
		run(SSE_OP_PUSH, 1'b0, 1'b1);
		rchk("keyed write", SSE_STAT_OFS, 16'h0000);
	endtask

	initial begin
		errors = 0;
		comparisons = 0;
		aresetn = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_bus();
		t_stack();
		t_exit();
		t_shift();
		t_wdog();
		wrap_up();
	end
endmodule

// ### verif/sse_host.sv
// Register-bus master standing in for software on the far side of the unit
`timescale 1ns/1ps

module sse_host
	import sse_pkg::*;
(
	input  wire logic                  aclk,
	input  wire sse_pkg::sse_axi_rsp_t axi_rsp,
	output      sse_pkg::sse_axi_req_t axi_req
);
	int hang;

	initial begin
		axi_req = '0;
		hang = 0;
	end

	// Each task is entered just after a rising edge and leaves just after one
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		resp = 2'h3;
		axi_req.awaddr <= a;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
			if (axi_req.bready && axi_rsp.bvalid) begin
				resp = axi_rsp.bresp;
				axi_req.bready <= 1'b0;
				// One idle edge so a following call never drives bready in the same step
				@(posedge aclk);
				break;
			end
		end
		if (n == 40) hang++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		d = '1;
		resp = 2'h3;
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
			if (axi_req.rready && axi_rsp.rvalid) begin
				d = axi_rsp.rdata;
				resp = axi_rsp.rresp;
				axi_req.rready <= 1'b0;
				@(posedge aclk);
				break;
			end
		end
		if (n == 40) hang++;
	endtask
endmodule
